// [logic/two_wire_serial_controller.v]
// byte-oriented two-wire serial bus controller, master and slave
//
// Function
// (RULE_01) master clock is oscillator divided by 16..960 per three rate bits
// (RULE_02) enable bit 6 low disables unit and releases both lines
// (RULE_03) begin request issues start when the bus is free
// (RULE_04) begin request on a busy bus gives a repeated start
// (RULE_05) end request as master places a stop on the bus
// (RULE_06) detected stop clears end request by hardware
// (RULE_07) stop is issued one service period after end request is set
// (RULE_08) address byte received sets match flag; software clears it
// (RULE_09) ack enable drives data low in acknowledge slot on reception
// (RULE_10) ack enable cleared leaves data released during acknowledge
// (RULE_11) service flag set on address, byte, or stop events as listed
// (RULE_12) reading status clears service flag
// (RULE_13) no service flag in display channel mode without software mode
// (RULE_14) shift register moves msb first, toward the high end
// (RULE_15) shift register holds byte to send or byte just received
// (RULE_16) status bit 6 set when a stop is received
// (RULE_17) status bit 4 shows transmitter role
// (RULE_18) status bit 3 shows another master holds the bus
// (RULE_19) status bit 2 shows arbitration lost
// (RULE_20) status bit 1 shows not-acknowledge from the receiver
// (RULE_21) status bit 0 shows slave role; bit 7 shows broadcast call
// (RULE_22) received address compared against seven-bit own address
// (RULE_23) status writes do nothing; reads only clear service flag
`include "two_wire_map.vh"

module two_wire_serial_controller (
  input  wire       core_clk,
  input  wire       rst_n,
  input  wire [2:0] reg_addr,
  input  wire [7:0] reg_wdata,
  input  wire       reg_write,
  input  wire       reg_read,
  output reg  [7:0] reg_rdata,
  input  wire       sda_in,
  output reg        sda_out,
  output reg        sda_oe,
  input  wire       scl_in,
  output reg        scl_out,
  output reg        scl_oe,
  output reg        service_irq
);

  // ********************
  // states
  // ********************
  localparam ST_IDLE  = 3'h0;
  localparam ST_START = 3'h1;
  localparam ST_BIT   = 3'h2;
  localparam ST_ACK   = 3'h3;
  localparam ST_HOLD  = 3'h4;
  localparam ST_STOP  = 3'h5;
  localparam ST_SLAVE = 3'h6;

  reg  [7:0] serial_control;
  reg  [7:0] serial_shift_data;
  reg  [7:0] own_address_reg;
  reg  [7:0] mode_reg;
  reg        broadcast_call_flag;
  reg        bus_end_seen_flag;
  reg        service_flag;
  reg        transmitter_flag;
  reg        arbitration_loss_flag;
  reg        ack_response_flag;
  reg        target_role_flag;
  reg        is_master;
  reg        addr_phase;
  reg  [2:0] state;
  reg  [1:0] phase;
  reg  [3:0] bit_cnt;
  reg        drive_sda_low;
  reg        drive_scl_low;
  reg        stop_armed;

  wire       tick;
  wire       start_seen;
  wire       stop_seen;
  wire       scl_rise;
  wire       scl_fall;
  wire       bus_busy;
  wire       enabled;
  wire       ack_enable;
  wire       irq_allowed;
  wire       status_read;
  wire [7:0] status_word;
  wire       addr_match;
  wire       bcast_match;
  reg        set_service;

  assign enabled     = serial_control[`CTL_ENABLE];
  assign ack_enable  = serial_control[`CTL_ACK];
  assign status_read = reg_read && (reg_addr == `OFS_STATUS);
  assign irq_allowed = !(mode_reg[`MODE_DISPLAY] && !mode_reg[`MODE_SOFTWARE]); // RULE_13
  assign addr_match  = serial_shift_data[7:1] == own_address_reg[7:1]; // RULE_22
  assign bcast_match = (serial_shift_data[7:1] == `BROADCAST_ADDR) && own_address_reg[0];
  assign status_word = {broadcast_call_flag, bus_end_seen_flag, service_flag,
                        transmitter_flag, bus_busy && !is_master,
                        arbitration_loss_flag, ack_response_flag, target_role_flag};

  rate_divider u_rate (
    .core_clk  (core_clk),
    .rst_n     (rst_n),
    .run       (enabled && is_master),
    .rate_code ({serial_control[`CTL_RATE2], serial_control[`CTL_RATE1],
                 serial_control[`CTL_RATE0]}),
    .tick      (tick)
  );

  line_watch u_watch (
    .core_clk   (core_clk),
    .rst_n      (rst_n),
    .sda_in     (sda_in),
    .scl_in     (scl_in),
    .start_seen (start_seen),
    .stop_seen  (stop_seen),
    .scl_rise   (scl_rise),
    .scl_fall   (scl_fall),
    .busy       (bus_busy)
  );

  // ********************
  // register file and protocol engine
  // ********************
  always @(posedge core_clk) begin
    if (!rst_n) begin
      serial_control        <= `RST_CONTROL;
      serial_shift_data     <= 8'h00;
      own_address_reg       <= `RST_OWN_ADDRESS;
      mode_reg              <= `RST_MODE;
      broadcast_call_flag   <= 1'b0;
      bus_end_seen_flag     <= 1'b0;
      service_flag          <= 1'b0;
      transmitter_flag      <= 1'b0;
      arbitration_loss_flag <= 1'b0;
      ack_response_flag     <= 1'b0;
      target_role_flag      <= 1'b0;
      is_master             <= 1'b0;
      addr_phase            <= 1'b0;
      state                 <= ST_IDLE;
      phase                 <= 2'h0;
      bit_cnt               <= 4'h0;
      drive_sda_low         <= 1'b0;
      drive_scl_low         <= 1'b0;
      stop_armed            <= 1'b0;
      set_service           <= 1'b0;
    end else begin
      set_service <= 1'b0;
      // software access; status writes ignored
      if (reg_write) begin // RULE_23
        case (reg_addr)
          `OFS_CONTROL:     serial_control <= reg_wdata;
          `OFS_SHIFT_DATA:  serial_shift_data <= reg_wdata; // RULE_15
          `OFS_OWN_ADDRESS: own_address_reg <= reg_wdata;
          `OFS_MODE:        mode_reg <= reg_wdata;
          default: ;
        endcase
      end
      if (reg_write && reg_addr == `OFS_CONTROL && reg_wdata[`CTL_END])
        stop_armed <= 1'b0;
      // service flag: set wins over read clear
      if (set_service && irq_allowed) // RULE_11 RULE_13
        service_flag <= 1'b1;
      else if (status_read)
        service_flag <= 1'b0; // RULE_12
      if (stop_seen) begin
        bus_end_seen_flag           <= 1'b1; // RULE_16
        serial_control[`CTL_END]    <= 1'b0; // RULE_06
        if (target_role_flag)
          set_service <= 1'b1; // RULE_11
        target_role_flag <= 1'b0;
        transmitter_flag <= 1'b0;
      end
      if (start_seen && !is_master)
        bus_end_seen_flag <= 1'b0;

      if (!enabled) begin // RULE_02
        state         <= ST_IDLE;
        is_master     <= 1'b0;
        drive_sda_low <= 1'b0;
        drive_scl_low <= 1'b0;
        target_role_flag <= 1'b0;
        transmitter_flag <= 1'b0;
      end else begin
        case (state)
          ST_IDLE: begin
            drive_sda_low <= 1'b0;
            drive_scl_low <= 1'b0;
            if (serial_control[`CTL_BEGIN] && !bus_busy) begin // RULE_03
              is_master             <= 1'b1;
              arbitration_loss_flag <= 1'b0;
              phase                 <= 2'h0;
              state                 <= ST_START;
            end else if (start_seen) begin
              state      <= ST_SLAVE;
              addr_phase <= 1'b1;
              bit_cnt    <= 4'h0;
            end
          end
          ST_START: if (tick) begin
            phase <= phase + 2'h1;
            case (phase)
              2'h0: drive_sda_low <= 1'b0;
              2'h1: drive_scl_low <= 1'b0;
              2'h2: drive_sda_low <= 1'b1;
              default: begin
                drive_scl_low              <= 1'b1;
                serial_control[`CTL_BEGIN] <= 1'b0;
                transmitter_flag           <= 1'b1; // RULE_17
                addr_phase                 <= 1'b1;
                bit_cnt                    <= 4'h0;
                state                      <= ST_BIT;
              end
            endcase
          end
          ST_BIT: if (tick) begin
            phase <= phase + 2'h1;
            case (phase)
              2'h0: drive_sda_low <= transmitter_flag && !serial_shift_data[7]; // RULE_14
              2'h1: drive_scl_low <= 1'b0;
              2'h2: if (scl_in) begin
                if (transmitter_flag && serial_shift_data[7] && !sda_in) begin
                  arbitration_loss_flag <= 1'b1; // RULE_19
                  is_master             <= 1'b0;
                  transmitter_flag      <= 1'b0;
                  drive_sda_low         <= 1'b0;
                  set_service           <= 1'b1;
                  state                 <= ST_IDLE;
                end
                serial_shift_data <= {serial_shift_data[6:0], sda_in}; // RULE_14
                bit_cnt <= bit_cnt + 4'h1;
              end else
                phase <= phase;
              default: begin
                drive_scl_low <= 1'b1;
                if (bit_cnt == 4'h8)
                  state <= ST_ACK;
              end
            endcase
          end
          ST_ACK: if (tick) begin
            phase <= phase + 2'h1;
            case (phase)
              // master receiver answers per ack enable
              2'h0: drive_sda_low <= !transmitter_flag && ack_enable; // RULE_09 RULE_10
              2'h1: drive_scl_low <= 1'b0;
              2'h2: if (transmitter_flag)
                ack_response_flag <= sda_in; // RULE_20
              default: begin
                drive_scl_low <= 1'b1;
                drive_sda_low <= 1'b0;
                set_service   <= 1'b1; // RULE_11
                if (addr_phase)
                  transmitter_flag <= !serial_shift_data[0];
                addr_phase <= 1'b0;
                bit_cnt    <= 4'h0;
                state      <= ST_HOLD;
              end
            endcase
          end
          ST_HOLD: begin
            // clock held low until an end or begin request, or a tick with the service flag clear; stop on the first tick after the end request is armed
            if (serial_control[`CTL_END] && !stop_armed) begin
              stop_armed <= 1'b1;
            end else if (serial_control[`CTL_END] && tick) begin // RULE_05 RULE_07
              stop_armed <= 1'b0;
              phase      <= 2'h0;
              state      <= ST_STOP;
            end else if (serial_control[`CTL_BEGIN] && tick) begin // RULE_04
              phase         <= 2'h0;
              drive_sda_low <= 1'b0;
              state         <= ST_START;
            end else if (!service_flag && tick) begin
              phase <= 2'h0;
              state <= ST_BIT;
            end
          end
          ST_STOP: if (tick) begin
            phase <= phase + 2'h1;
            case (phase)
              2'h0: drive_sda_low <= 1'b1;
              2'h1: drive_scl_low <= 1'b0;
              2'h2: drive_sda_low <= 1'b0;
              default: begin
                is_master        <= 1'b0;
                transmitter_flag <= 1'b0;
                state            <= ST_IDLE;
              end
            endcase
          end
          ST_SLAVE: begin
            if (stop_seen || start_seen) begin
              drive_sda_low <= 1'b0;
              addr_phase    <= start_seen;
              bit_cnt       <= 4'h0;
              if (stop_seen)
                state <= ST_IDLE;
            end else if (scl_rise && bit_cnt < 4'h8) begin
              serial_shift_data <= {serial_shift_data[6:0], sda_in}; // RULE_14
              bit_cnt <= bit_cnt + 4'h1;
            end else if (scl_fall && bit_cnt == 4'h8) begin
              bit_cnt <= 4'h9;
              if (addr_phase) begin
                serial_control[`CTL_MATCH] <= 1'b1; // RULE_08
                if (ack_enable && (addr_match || bcast_match)) begin // RULE_22
                  drive_sda_low       <= 1'b1; // RULE_09
                  target_role_flag    <= 1'b1; // RULE_21
                  broadcast_call_flag <= bcast_match; // RULE_21
                  transmitter_flag    <= serial_shift_data[0] && !bcast_match;
                  set_service         <= 1'b1; // RULE_11
                end else
                  state <= ST_IDLE;
              end else if (!transmitter_flag) begin
                drive_sda_low <= ack_enable; // RULE_09 RULE_10
                set_service   <= 1'b1; // RULE_11
              end
            end else if (scl_rise && bit_cnt == 4'h9 && transmitter_flag && !addr_phase) begin
              ack_response_flag <= sda_in; // RULE_20
              set_service       <= 1'b1;
            end else if (scl_fall && bit_cnt == 4'h9) begin
              addr_phase    <= 1'b0;
              bit_cnt       <= 4'h0;
              drive_sda_low <= transmitter_flag && !serial_shift_data[7];
            end else if (scl_fall && transmitter_flag && bit_cnt < 4'h8) begin
              drive_sda_low <= !serial_shift_data[7]; // RULE_14
            end
          end
          default: state <= ST_IDLE;
        endcase
      end
    end
  end

  // ********************
  // registered outputs
  // ********************
  always @(posedge core_clk) begin
    if (!rst_n) begin
      reg_rdata   <= 8'h00;
      sda_out     <= 1'b0;
      sda_oe      <= 1'b0;
      scl_out     <= 1'b0;
      scl_oe      <= 1'b0;
      service_irq <= 1'b0;
    end else begin
      sda_out     <= 1'b0;
      scl_out     <= 1'b0;
      sda_oe      <= enabled && drive_sda_low; // RULE_02
      scl_oe      <= enabled && drive_scl_low; // RULE_02
      service_irq <= service_flag;
      reg_rdata   <= 8'h00;
      if (reg_read) begin
        case (reg_addr)
          `OFS_CONTROL:     reg_rdata <= serial_control;
          `OFS_STATUS:      reg_rdata <= status_word; // RULE_18
          `OFS_SHIFT_DATA:  reg_rdata <= serial_shift_data; // RULE_15
          `OFS_OWN_ADDRESS: reg_rdata <= own_address_reg;
          `OFS_MODE:        reg_rdata <= mode_reg;
          default:          reg_rdata <= 8'h00;
        endcase
      end
    end
  end

endmodule

// [logic/two_wire_map.vh]
// register offsets, field positions, reset values and timing counts
`ifndef TWO_WIRE_MAP_VH
`define TWO_WIRE_MAP_VH

// ********************
// register offsets
// ********************
`define OFS_CONTROL      3'h0
`define OFS_STATUS       3'h1
`define OFS_SHIFT_DATA   3'h2
`define OFS_OWN_ADDRESS  3'h3
`define OFS_MODE         3'h4

// ********************
// control fields
// ********************
`define CTL_RATE2        7
`define CTL_ENABLE       6
`define CTL_BEGIN        5
`define CTL_END          4
`define CTL_MATCH        3
`define CTL_ACK          2
`define CTL_RATE1        1
`define CTL_RATE0        0

// ********************
// status fields
// ********************
`define STA_BROADCAST    7
`define STA_END_SEEN     6
`define STA_SERVICE      5
`define STA_TRANSMIT     4
`define STA_OCCUPIED     3
`define STA_ARB_LOSS     2
`define STA_NACK         1
`define STA_TARGET       0

// ********************
// mode register fields
// ********************
`define MODE_DISPLAY     0
`define MODE_SOFTWARE    1

// ********************
// reset values and timing
// ********************
`define RST_CONTROL      8'h00
`define RST_OWN_ADDRESS  8'h00
`define RST_MODE         8'h00
`define BROADCAST_ADDR   7'h00
`define CLK_NS           25
`define HOLD_NS          600
`define HOLD_CYCLES      ((`HOLD_NS + `CLK_NS - 1) / `CLK_NS)

`endif

// [logic/rate_divider.v]
// quarter-bit enable pulse for the master serial clock
`include "two_wire_map.vh"

module rate_divider (
  input  wire       core_clk,
  input  wire       rst_n,
  input  wire       run,
  input  wire [2:0] rate_code,
  output reg        tick
);

  reg  [7:0] count;
  wire [7:0] limit;

  // ********************
  // divisor to quarter period
  // ********************
  // each bit has four phases, so one phase lasts divisor/4 cycles
  function [7:0] quarter;
    input [2:0] code;
    begin
      case (code)
        3'h0: quarter = 8'h04;
        3'h1: quarter = 8'h06;
        3'h2: quarter = 8'h08;
        3'h3: quarter = 8'h0f;
        3'h4: quarter = 8'h1e;
        3'h5: quarter = 8'h3c;
        3'h6: quarter = 8'h78;
        default: quarter = 8'hf0;
      endcase
    end
  endfunction

  assign limit = quarter(rate_code); // RULE_01

  always @(posedge core_clk) begin
    if (!rst_n || !run) begin
      count <= 8'h00;
      tick  <= 1'b0;
    end else if (count >= limit - 8'h01) begin
      count <= 8'h00;
      tick  <= 1'b1;
    end else begin
      count <= count + 8'h01;
      tick  <= 1'b0;
    end
  end

endmodule

// [logic/line_watch.v]
// start and stop condition detector on the sampled bus lines
`include "two_wire_map.vh"

module line_watch (
  input  wire core_clk,
  input  wire rst_n,
  input  wire sda_in,
  input  wire scl_in,
  output reg  start_seen,
  output reg  stop_seen,
  output reg  scl_rise,
  output reg  scl_fall,
  output reg  busy
);

  reg sda_q;
  reg scl_q;

  always @(posedge core_clk) begin
    if (!rst_n) begin
      sda_q      <= 1'b1;
      scl_q      <= 1'b1;
      start_seen <= 1'b0;
      stop_seen  <= 1'b0;
      scl_rise   <= 1'b0;
      scl_fall   <= 1'b0;
      busy       <= 1'b0;
    end else begin
      sda_q      <= sda_in;
      scl_q      <= scl_in;
      start_seen <= scl_in && scl_q && sda_q && !sda_in;
      stop_seen  <= scl_in && scl_q && !sda_q && sda_in;
      scl_rise   <= scl_in && !scl_q;
      scl_fall   <= !scl_in && scl_q;
      if (scl_in && scl_q && sda_q && !sda_in)
        busy <= 1'b1;
      else if (scl_in && scl_q && !sda_q && sda_in)
        busy <= 1'b0;
    end
  end

endmodule

// [dv/two_wire_props.sv]
// port-level assertion checker for the two-wire controller
`include "two_wire_map.vh"

module two_wire_props (
  input wire logic       core_clk,
  input wire logic       rst_n,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_write,
  input wire logic       reg_read,
  input wire logic [7:0] reg_rdata,
  input wire logic       sda_in,
  input wire logic       sda_out,
  input wire logic       sda_oe,
  input wire logic       scl_in,
  input wire logic       scl_out,
  input wire logic       scl_oe,
  input wire logic       service_irq
);
  timeunit 1ns;
  timeprecision 1ps;

  // ********************
  // shadow state
  // ********************
  logic       en_q;
  logic       quiet_q;
  logic [3:0] stop_age;

  always @(posedge core_clk) begin
    if (!rst_n) begin
      en_q    <= 1'b0;
      quiet_q <= 1'b0;
    end else if (reg_write && reg_addr == `OFS_CONTROL) begin
      en_q <= reg_wdata[`CTL_ENABLE];
    end else if (reg_write && reg_addr == `OFS_MODE) begin
      quiet_q <= reg_wdata[`MODE_DISPLAY] && !reg_wdata[`MODE_SOFTWARE];
    end
  end

  // cycles since a stop on the lines, zero after a start
  always @(posedge core_clk) begin
    if (!rst_n || (scl_in && $fell(sda_in))) begin
      stop_age <= 4'h0;
    end else if (scl_in && $rose(sda_in)) begin
      stop_age <= 4'h1;
    end else if (stop_age != 4'h0 && stop_age != 4'hf) begin
      stop_age <= stop_age + 4'h1;
    end
  end

  // ********************
  // properties
  // ********************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  property p_lines_off;
    !en_q && !$past(en_q) |-> !sda_oe && !scl_oe;
  endproperty
  a_lines_off: assert property (p_lines_off) else $error("line driven while disabled");

  property p_open_drain;
    sda_out == 1'b0 && scl_out == 1'b0;
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("line driven high");

  property p_irq_clear;
    reg_read && reg_addr == `OFS_STATUS && service_irq |-> ##2 !service_irq;
  endproperty
  a_irq_clear: assert property (p_irq_clear) else $error("status read kept irq");

  property p_quiet;
    quiet_q && $past(quiet_q) |-> !$rose(service_irq);
  endproperty
  a_quiet: assert property (p_quiet) else $error("irq in display mode");

  property p_start;
    reg_write && reg_addr == `OFS_CONTROL && reg_wdata[`CTL_ENABLE] && reg_wdata[`CTL_BEGIN]
      |-> ##[1:1000] ($rose(sda_oe) && scl_in);
  endproperty
  a_start: assert property (p_start) else $error("no start after begin");

  property p_stop;
    reg_write && reg_addr == `OFS_CONTROL && reg_wdata[`CTL_ENABLE] && reg_wdata[`CTL_END]
      && !reg_wdata[`CTL_RATE2] |-> ##[1:1000] ($fell(sda_oe) && scl_in);
  endproperty
  a_stop: assert property (p_stop) else $error("no stop after end request");

  property p_shift_back;
    reg_write && reg_addr == `OFS_SHIFT_DATA ##1 reg_read && reg_addr == `OFS_SHIFT_DATA
      |=> reg_rdata == $past(reg_wdata, 2);
  endproperty
  a_shift_back: assert property (p_shift_back) else $error("shift data lost");

  property p_end_seen;
    reg_read && reg_addr == `OFS_STATUS && stop_age > 4'h4 |=> reg_rdata[`STA_END_SEEN];
  endproperty
  a_end_seen: assert property (p_end_seen) else $error("stop flag missing");

  property p_end_clear;
    reg_read && reg_addr == `OFS_CONTROL && stop_age > 4'h4 |=> !reg_rdata[`CTL_END];
  endproperty
  a_end_clear: assert property (p_end_clear) else $error("end request not cleared");

  c_begin: cover property (reg_write && reg_addr == `OFS_CONTROL && reg_wdata[`CTL_BEGIN]);
  c_irq: cover property ($rose(service_irq));
  c_stop: cover property (scl_in && $rose(sda_in));
endmodule

bind two_wire_serial_controller two_wire_props u_props (
  .core_clk, .rst_n, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
  .sda_in, .sda_out, .sda_oe, .scl_in, .scl_out, .scl_oe, .service_irq
);

// [dv/bus_partner.sv]
// behavioural slave on the shared two-wire lines
module bus_partner #(
  parameter logic [6:0] OWN_ADDR = 7'h2a
) (
  input  wire logic       scl,
  input  wire logic       sda,
  input  wire logic [7:0] tx_byte,
  output logic            sda_pull,
  output logic [7:0]      rx_byte,
  output logic            ack_seen
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [7:0] sh;

  initial begin
    sda_pull = 1'b0;
    ack_seen = 1'b0;
    rx_byte  = 8'h00;
    forever begin
      @(negedge sda iff scl === 1'b1);
      for (int i = 0; i < 8; i++) begin
        @(posedge scl);
        sh = {sh[6:0], sda};
      end
      rx_byte = sh;
      @(negedge scl);
      if (sh[7:1] == OWN_ADDR) begin
        sda_pull = 1'b1;
        @(negedge scl);
        sda_pull = 1'b0;
        if (sh[0]) begin
          for (int i = 0; i < 8; i++) begin
            sda_pull = ~tx_byte[7 - i];
            @(negedge scl);
          end
          sda_pull = 1'b0;
          @(posedge scl);
          ack_seen = ~sda;
        end
      end
    end
  end
endmodule

// [dv/tb.sv]
// self-checking bench for the two-wire serial controller
`include "two_wire_map.vh"

module tb;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [6:0] PEER = 7'h2a;
  localparam int QUARTER [8] = '{4, 6, 8, 15, 30, 60, 120, 240};

  logic       core_clk  = 1'b0;
  logic       rst_n     = 1'b0;
  logic       reg_write = 1'b0;
  logic       reg_read  = 1'b0;
  logic [2:0] reg_addr  = 3'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] tx_byte   = 8'hc5;
  logic [7:0] reg_rdata, rd, st, rx_byte;
  logic       sda_out, sda_oe, scl_out, scl_oe, service_irq, sda_pull, ack_seen;
  int         miscompares = 0;
  int         cmp_count   = 0;
  int         period      = 0;
  int         cnt         = 0;
  wire        sda = ~(sda_oe | sda_pull);
  wire        scl = ~scl_oe;

  always #12.5 core_clk = ~core_clk;

  two_wire_serial_controller u_dut (
    .core_clk, .rst_n, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
    .sda_in(sda), .sda_out, .sda_oe, .scl_in(scl), .scl_out, .scl_oe, .service_irq
  );

  bus_partner #(.OWN_ADDR(PEER)) u_partner (
    .scl, .sda, .tx_byte, .sda_pull, .rx_byte, .ack_seen
  );

  // cycles between successive pulls of the clock line
  always @(posedge core_clk) begin
    if ($rose(scl_oe)) begin
      period <= cnt;
      cnt    <= 1;
    end else begin
      cnt <= cnt + 1;
    end
  end

  // ********************
  // shared tasks
  // ********************
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge core_clk);
    reg_write <= 1'b0;
  endtask

  task automatic rdr(input logic [2:0] a, output logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge core_clk);
    reg_read <= 1'b0;
    #1 d = reg_rdata;
  endtask

  function automatic logic [7:0] ctl(input logic [2:0] c, input logic b, e, a);
    return {c[2], 1'b1, b, e, 1'b0, a, c[1:0]};
  endfunction

  task automatic wait_irq();
    int n;
    n = 0;
    repeat (2) @(posedge core_clk);
    while (service_irq !== 1'b1 && n < 20000) begin
      @(posedge core_clk);
      n++;
    end
    chk({15'h0, service_irq}, 16'h1);
  endtask

  // end request before the status read: the end request, not the read, takes the held clock on to the stop
  task automatic end_frame(input logic [2:0] c, input logic a);
    int n;
    wr(`OFS_CONTROL, ctl(c, 1'b0, 1'b1, a));
    rdr(`OFS_STATUS, st);
    n = 0;
    rd = 8'hff;
    while (rd[`CTL_END] !== 1'b0 && n < 400) begin
      repeat (8) @(posedge core_clk);
      rdr(`OFS_CONTROL, rd);
      n++;
    end
    chk({15'h0, rd[`CTL_END]}, 16'h0);
    rdr(`OFS_STATUS, rd);
    chk({14'h0, rd[`STA_END_SEEN], rd[`STA_OCCUPIED]}, 16'h2);
  endtask

  // ********************
  // scenarios
  // ********************
  task automatic t_regs();
    chk({14'h0, sda_oe, scl_oe}, 16'h0);
    rdr(`OFS_CONTROL, rd);
    chk(rd, `RST_CONTROL);
    rdr(3'h5, rd);
    chk(rd, 8'h00);
    rdr(`OFS_STATUS, st);
    wr(`OFS_STATUS, 8'hff);
    rdr(`OFS_STATUS, rd);
    chk(rd, st);
    wr(`OFS_MODE, 8'h01);
    rdr(`OFS_MODE, rd);
    chk(rd, 8'h01);
    wr(`OFS_MODE, 8'h00);
    @(posedge core_clk);
    reg_addr  <= `OFS_SHIFT_DATA;
    reg_wdata <= 8'h3c;
    reg_write <= 1'b1;
    @(posedge core_clk);
    reg_write <= 1'b0;
    reg_read  <= 1'b1;
    @(posedge core_clk);
    reg_read <= 1'b0;
    #1 chk(reg_rdata, 8'h3c);
    $display("test regs done");
  endtask

  task automatic t_rates();
    logic [6:0] adr;
    for (int i = 0; i < 8; i++) begin
      adr = (i == 0) ? PEER : PEER + 7'h1;
      wr(`OFS_SHIFT_DATA, {adr, 1'b0});
      wr(`OFS_CONTROL, ctl(3'(i), 1'b1, 1'b0, 1'b1));
      wait_irq();
      chk(16'(period), 16'(4 * QUARTER[i]));
      chk(rx_byte, {adr, 1'b0});
      end_frame(3'(i), 1'b1);
      chk(st & 8'h37, {2'h0, 4'hc, i != 0, 1'b0});
    end
    $display("test rates done");
  endtask

  task automatic t_reads();
    for (int a = 1; a >= 0; a--) begin
      wr(`OFS_SHIFT_DATA, {PEER, 1'b1});
      wr(`OFS_CONTROL, ctl(3'h0, 1'b1, 1'b0, a[0]));
      wait_irq();
      rdr(`OFS_STATUS, rd);
      chk({15'h0, rd[`STA_SERVICE]}, 16'h1);
      repeat (2) @(posedge core_clk);
      #1 chk({15'h0, service_irq}, 16'h0);
      wait_irq();
      rdr(`OFS_SHIFT_DATA, rd);
      chk(rd, tx_byte);
      chk({15'h0, ack_seen}, {15'h0, a[0]});
      end_frame(3'h0, a[0]);
      chk({14'h0, st[`STA_SERVICE], st[`STA_TRANSMIT]}, 16'h2);
    end
    $display("test reads done");
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    repeat (6) @(posedge core_clk);
    rst_n <= 1'b1;
    t_regs();
    t_rates();
    t_reads();
    tally_and_finish();
  end

  initial begin
    #1000000;
    miscompares++;
    tally_and_finish();
  end
endmodule
